// ---- inc/fra_pkg.sv ----
package fra_pkg;
	localparam int FRA_DATA_W  = 8;
	localparam int FRA_ADDR_W  = 7;
	localparam int FRA_PC_W    = 15;
	localparam int FRA_HOLD_W  = 7;
	localparam int FRA_DEPTH   = 128;
	// low program counter field width taken from the accumulator
	localparam int FRA_PCLO_W  = 8;
	localparam logic [FRA_DATA_W-1:0] FRA_ACC_RST  = 8'h00;
	localparam logic [FRA_DATA_W-1:0] FRA_FILE_RST = 8'h00;
	localparam logic [FRA_DATA_W-1:0] FRA_ZERO     = 8'h00;
	localparam logic [FRA_DATA_W-1:0] FRA_ONE      = 8'h01;
	localparam logic [FRA_PC_W-1:0]   FRA_PC_RST   = 15'h0000;
	localparam logic [FRA_PC_W-1:0]   FRA_PC_STEP  = 15'h0001;
	localparam logic                  FRA_NULL_RST = 1'b0;
	// instruction cycles of the two-cycle operations
	localparam int FRA_CALL_CYCLES = 2;
	localparam int FRA_SKIP_CYCLES = 2;

	typedef enum logic [2:0] {
		FRA_OP_NOP   = 3'h0,
		FRA_OP_CALL_VIA_ACCUMULATOR = 3'h1,
		FRA_OP_COMPLEMENT_FILE_OP  = 3'h2,
		FRA_OP_CLEAR_FILE_OP  = 3'h3,
		FRA_OP_DECREMENT_FILE_OP  = 3'h4,
		FRA_OP_CLEAR_ACCUMULATOR_OP  = 3'h5,
		FRA_OP_DSKIP = 3'h6,
		FRA_OP_ISKIP = 3'h7
	} fra_op_e;

	typedef enum logic [1:0] {
		FRA_ST_RUN   = 2'h0,
		FRA_ST_CALL2 = 2'h1,
		FRA_ST_SKIP  = 2'h2
	} fra_state_e;
endpackage

// ---- inc/fra_file_if.sv ----
`timescale 1ns/1ps
interface fra_file_if;
	import fra_pkg::*;
	logic                  wr_en;
	logic [FRA_ADDR_W-1:0] wr_addr;
	logic [FRA_DATA_W-1:0] wr_data;
	logic [FRA_ADDR_W-1:0] rd_addr;
	logic [FRA_DATA_W-1:0] rd_data;
	logic [FRA_ADDR_W-1:0] peek_addr;
	logic [FRA_DATA_W-1:0] peek_data;
	modport core (output wr_en, wr_addr, wr_data, rd_addr, peek_addr, input rd_data, peek_data);
	modport mem (input wr_en, wr_addr, wr_data, rd_addr, peek_addr, output rd_data, peek_data);
endinterface

// ---- core/fra_file_mem.sv ----
`timescale 1ns/1ps
module fra_file_mem (
	input wire logic ref_clk,
	input wire logic rst_n,
	fra_file_if.mem  fif
);
	import fra_pkg::*;

	logic [FRA_DATA_W-1:0] mem_ff [FRA_DEPTH];
	logic [FRA_DATA_W-1:0] peek_ff;

	genvar gi;
	generate
		for (gi = 0; gi < FRA_DEPTH; gi++) begin : g_cell
			wire hit = fif.wr_en && (fif.wr_addr == FRA_ADDR_W'(gi));
			always_ff @(posedge ref_clk) begin
				if (!rst_n) begin
					mem_ff[gi] <= FRA_FILE_RST;
				end else if (hit) begin
					mem_ff[gi] <= fif.wr_data;
				end
			end
		end
	endgenerate

	// operand read is combinational so the result lands in the issue cycle
	assign fif.rd_data = mem_ff[fif.rd_addr];

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			peek_ff <= FRA_FILE_RST;
		end else begin
			peek_ff <= mem_ff[fif.peek_addr];
		end
	end
	assign fif.peek_data = peek_ff;
endmodule // fra_file_mem

// ---- core/fra_core.sv ----
`timescale 1ns/1ps
// Function
// - indirect call loads accumulator into pc low byte, holding bits into pc high
// - indirect call pushes pc plus one to the stack; flags untouched
// - indirect call takes two instruction cycles
// - file ops use 7-bit address; destination 0 accumulator, 1 the file register
// - complement writes inverse to destination, updates only the null flag
// - clear file writes zero to the register and sets the null flag
// - decrement writes register minus one to destination, updates only null flag
// - clear accumulator writes zero to accumulator and sets the null flag
// - decrement skip: no flag change; zero result replaces next instruction by nop
// - increment skip: no flag change; zero result replaces next instruction by nop
// - skip ops with nonzero result continue normally without a lost cycle
module fra_core (
	input  wire logic                             ref_clk,
	input  wire logic                             rst_n,
	input  wire logic                             op_valid,
	input  wire fra_pkg::fra_op_e                 op_code,
	input  wire logic [fra_pkg::FRA_ADDR_W-1:0]   op_faddr,
	input  wire logic                             op_dest,
	input  wire logic [fra_pkg::FRA_HOLD_W-1:0]   upper_pc_holding,
	input  wire logic [fra_pkg::FRA_ADDR_W-1:0]   peek_addr,
	output logic                                  op_ready,
	output logic [fra_pkg::FRA_DATA_W-1:0]        acc,
	output logic                                  result_null_flag,
	output logic [fra_pkg::FRA_PC_W-1:0]          pc,
	output logic                                  push_valid,
	output logic [fra_pkg::FRA_PC_W-1:0]          stack_top_data,
	output logic                                  nop_slot,
	output logic [fra_pkg::FRA_DATA_W-1:0]        peek_data
);
	import fra_pkg::*;

	fra_file_if fif ();

	fra_file_mem u_mem (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.fif     (fif)
	);

	function automatic logic is_dest_op(input fra_op_e op);
		return (op == FRA_OP_COMPLEMENT_FILE_OP) || (op == FRA_OP_DECREMENT_FILE_OP) || (op == FRA_OP_DSKIP) || (op == FRA_OP_ISKIP);
	endfunction

	function automatic logic is_skip_op(input fra_op_e op);
		return (op == FRA_OP_DSKIP) || (op == FRA_OP_ISKIP);
	endfunction

	fra_state_e                state_ff;
	fra_state_e                nxt_state;
	logic [FRA_DATA_W-1:0]     acc_ff;
	logic [FRA_DATA_W-1:0]     nxt_acc;
	logic                      null_ff;
	logic                      nxt_null;
	logic [FRA_PC_W-1:0]       pc_ff;
	logic [FRA_PC_W-1:0]       nxt_pc;
	logic [FRA_HOLD_W-1:0]     hold_ff;
	logic                      push_ff;
	logic [FRA_PC_W-1:0]       tos_ff;

	wire                       take      = op_valid && op_ready;
	wire [FRA_DATA_W-1:0]      f_val     = fif.rd_data;
	wire [FRA_DATA_W-1:0]      res_complement_file_op  = ~f_val;
	wire [FRA_DATA_W-1:0]      res_dec   = f_val - FRA_ONE;
	wire [FRA_DATA_W-1:0]      res_inc   = f_val + FRA_ONE;
	wire                       op_call   = (op_code == FRA_OP_CALL_VIA_ACCUMULATOR);
	wire                       op_clear_file_op   = (op_code == FRA_OP_CLEAR_FILE_OP);
	wire                       op_clear_accumulator_op   = (op_code == FRA_OP_CLEAR_ACCUMULATOR_OP);
	wire                       op_flagz  = (op_code == FRA_OP_COMPLEMENT_FILE_OP) || (op_code == FRA_OP_DECREMENT_FILE_OP);
	wire                       dest_op   = is_dest_op(op_code);
	wire                       skip_op   = is_skip_op(op_code);
	wire [FRA_PC_W-1:0]        pc_inc    = pc_ff + FRA_PC_STEP;
	wire [FRA_PC_W-1:0]        call_tgt  = {hold_ff, acc_ff[FRA_PCLO_W-1:0]};

	wire [FRA_DATA_W-1:0] result =
		(op_code == FRA_OP_COMPLEMENT_FILE_OP)                           ? res_complement_file_op :
		(op_code == FRA_OP_DECREMENT_FILE_OP || op_code == FRA_OP_DSKIP) ? res_dec  :
		(op_code == FRA_OP_ISKIP)                          ? res_inc  :
		FRA_ZERO;
	wire res_zero = (result == FRA_ZERO);

	// clear file has no destination choice: it always writes the register
	wire wr_file = take && (op_clear_file_op || (dest_op && op_dest));
	wire wr_acc  = take && ((dest_op && !op_dest) || op_clear_accumulator_op);
	// a nop slot only on a zero result; otherwise the next issue is not delayed
	wire do_skip = take && skip_op && res_zero;

	assign fif.rd_addr   = op_faddr;
	assign fif.wr_addr   = op_faddr;
	assign fif.wr_en     = wr_file;
	assign fif.wr_data   = result;
	assign fif.peek_addr = peek_addr;

	assign nxt_acc = wr_acc ? result : acc_ff;

	// skip ops and the call leave the flag alone
	assign nxt_null = (take && (op_clear_file_op || op_clear_accumulator_op)) ? 1'b1 :
		(take && op_flagz) ? res_zero : null_ff;

	assign nxt_state = (take && op_call) ? FRA_ST_CALL2 :
		do_skip ? FRA_ST_SKIP : FRA_ST_RUN;

	// the skipped instruction is discarded, so the pc still steps over it
	assign nxt_pc = (state_ff == FRA_ST_CALL2) ? call_tgt :
		(take || state_ff == FRA_ST_SKIP) ? pc_inc : pc_ff;

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			state_ff <= FRA_ST_RUN;
			acc_ff   <= FRA_ACC_RST;
			null_ff  <= FRA_NULL_RST;
			pc_ff    <= FRA_PC_RST;
		end else begin
			state_ff <= nxt_state;
			acc_ff   <= nxt_acc;
			null_ff  <= nxt_null;
			pc_ff    <= nxt_pc;
		end
	end

	// holding bits are caught at issue so a late change cannot tear the target
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			hold_ff <= '0;
			push_ff <= 1'b0;
			tos_ff  <= FRA_PC_RST;
		end else begin
			push_ff <= take && op_call;
			if (take && op_call) begin
				hold_ff <= upper_pc_holding;
				tos_ff  <= pc_inc;
			end
		end
	end

	assign op_ready         = (state_ff == FRA_ST_RUN);
	assign nop_slot         = (state_ff == FRA_ST_SKIP);
	assign acc              = acc_ff;
	assign result_null_flag = null_ff;
	assign pc               = pc_ff;
	assign push_valid       = push_ff;
	assign stack_top_data   = tos_ff;
	assign peek_data        = fif.peek_data;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	sequence s_call_issue;
		take && op_call;
	endsequence

	sequence s_call_busy;
		!op_ready ##1 op_ready;
	endsequence

	sequence s_zero_skip(fra_op_e op);
		take && (op_code == op) && res_zero;
	endsequence

	sequence s_nop_then_run;
		nop_slot && !op_ready ##1 op_ready && !nop_slot;
	endsequence

	a_call_target_load: assert property (
		s_call_issue |-> ##2 pc_ff == {$past(upper_pc_holding, 2), $past(acc_ff, 2)})
		else $error("call target not taken from accumulator and holding bits");

	a_call_push_addr: assert property (
		s_call_issue |=> push_valid && stack_top_data == $past(pc_ff) + FRA_PC_STEP
			&& result_null_flag == $past(null_ff))
		else $error("call return address wrong or flag disturbed");

	a_call_two_cycles: assert property (
		s_call_issue |=> s_call_busy)
		else $error("call did not take two cycles");

	a_dest_acc_route: assert property (
		take && dest_op && !op_dest |-> !fif.wr_en ##1 acc_ff == $past(result))
		else $error("destination zero not routed to accumulator");

	a_dest_file_route: assert property (
		take && dest_op && op_dest |-> fif.wr_en && fif.wr_addr == op_faddr ##1 acc_ff == $past(acc_ff))
		else $error("destination one not routed to file register");

	a_complement_file_op_value: assert property (
		take && op_code == FRA_OP_COMPLEMENT_FILE_OP |-> fif.wr_data == ~f_val
			##1 result_null_flag == ($past(f_val) == 8'hff))
		else $error("complement result or flag wrong");

	a_clear_file_op_zero_set: assert property (
		take && op_clear_file_op |-> fif.wr_en && fif.wr_data == FRA_ZERO ##1 result_null_flag)
		else $error("clear file did not zero register or set flag");

	a_decrement_file_op_value: assert property (
		take && op_code == FRA_OP_DECREMENT_FILE_OP && !op_dest |=> acc_ff == $past(f_val) - FRA_ONE
			&& result_null_flag == ($past(f_val) == FRA_ONE))
		else $error("decrement result or flag wrong");

	a_clear_accumulator_op_zero_set: assert property (
		take && op_clear_accumulator_op |=> acc_ff == FRA_ZERO && result_null_flag)
		else $error("clear accumulator wrong");

	a_dskip_nop: assert property (
		s_zero_skip(FRA_OP_DSKIP) |=> s_nop_then_run and $stable(result_null_flag))
		else $error("decrement skip did not insert nop or changed flag");

	a_iskip_nop: assert property (
		s_zero_skip(FRA_OP_ISKIP) |=> s_nop_then_run and $stable(result_null_flag))
		else $error("increment skip did not insert nop or changed flag");

	a_skip_no_loss: assert property (
		take && skip_op && !res_zero |=> op_ready && !nop_slot && pc_ff == $past(pc_ff) + FRA_PC_STEP
			&& $stable(result_null_flag))
		else $error("nonzero skip result lost a cycle");

	a_null_clear: assert property (
		take && op_flagz && !res_zero |=> !result_null_flag)
		else $error("null flag not cleared for nonzero result");

	a_skip_pc_step: assert property (
		do_skip |-> ##2 pc_ff == $past(pc_ff, 2) + 15'h0002)
		else $error("skipped instruction not stepped over");
endmodule // fra_core

// ---- sim/fra_core_tb.sv ----
`timescale 1ns/1ps
module fra_core_tb;
	import fra_pkg::*;
	logic                  ref_clk;
	logic                  rst_n;
	logic                  op_valid;
	fra_op_e               op_code;
	logic [FRA_ADDR_W-1:0] op_faddr;
	logic                  op_dest;
	logic [FRA_HOLD_W-1:0] upper_pc_holding;
	logic [FRA_ADDR_W-1:0] peek_addr;
	logic                  op_ready;
	logic [FRA_DATA_W-1:0] acc;
	logic                  result_null_flag;
	logic [FRA_PC_W-1:0]   pc;
	logic                  push_valid;
	logic [FRA_PC_W-1:0]   stack_top_data;
	logic                  nop_slot;
	logic [FRA_DATA_W-1:0] peek_data;
	int                    bad_count;
	int                    samples_checked;
	logic [FRA_PC_W-1:0]   pc_start;

	fra_core fra_core_i (
		.ref_clk          (ref_clk),
		.rst_n            (rst_n),
		.op_valid         (op_valid),
		.op_code          (op_code),
		.op_faddr         (op_faddr),
		.op_dest          (op_dest),
		.upper_pc_holding (upper_pc_holding),
		.peek_addr        (peek_addr),
		.op_ready         (op_ready),
		.acc              (acc),
		.result_null_flag (result_null_flag),
		.pc               (pc),
		.push_valid       (push_valid),
		.stack_top_data   (stack_top_data),
		.nop_slot         (nop_slot),
		.peek_data        (peek_data)
	);

	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end

	task automatic chk(input string what, input logic [FRA_PC_W-1:0] exp, input logic [FRA_PC_W-1:0] got);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask

	// called at a falling edge; holds the request over exactly one rising edge
	task automatic issue(input fra_op_e op, input logic [FRA_ADDR_W-1:0] fa, input logic d);
		op_valid = 1'b1;
		op_code  = op;
		op_faddr = fa;
		op_dest  = d;
		@(negedge ref_clk);
	endtask

	// peek also drops the request, so a pending op is never repeated
	task automatic peek(input logic [FRA_ADDR_W-1:0] a, input logic [FRA_DATA_W-1:0] exp);
		op_valid  = 1'b0;
		peek_addr = a;
		@(negedge ref_clk);
		chk("peek_data", FRA_PC_W'(exp), FRA_PC_W'(peek_data));
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic t_clear();
		issue(FRA_OP_CLEAR_ACCUMULATOR_OP, 7'h00, 1'b0);
		chk("acc", 15'h0000, FRA_PC_W'(acc));
		chk("null_flag", 15'h0001, FRA_PC_W'(result_null_flag));
		issue(FRA_OP_COMPLEMENT_FILE_OP, 7'h7F, 1'b1);
		chk("null_flag", 15'h0000, FRA_PC_W'(result_null_flag));
		chk("acc", 15'h0000, FRA_PC_W'(acc));
		peek(7'h7F, 8'hFF);
		issue(FRA_OP_CLEAR_FILE_OP, 7'h7F, 1'b0);
		chk("null_flag", 15'h0001, FRA_PC_W'(result_null_flag));
		peek(7'h7F, 8'h00);
		$display("test clear done");
	endtask

	task automatic t_dec();
		issue(FRA_OP_ISKIP, 7'h05, 1'b1);
		chk("nop_slot", 15'h0000, FRA_PC_W'(nop_slot));
		chk("op_ready", 15'h0001, FRA_PC_W'(op_ready));
		chk("null_flag", 15'h0001, FRA_PC_W'(result_null_flag));
		issue(FRA_OP_COMPLEMENT_FILE_OP, 7'h05, 1'b0);
		chk("acc", 15'h00FE, FRA_PC_W'(acc));
		chk("null_flag", 15'h0000, FRA_PC_W'(result_null_flag));
		issue(FRA_OP_DECREMENT_FILE_OP, 7'h05, 1'b0);
		chk("acc", 15'h0000, FRA_PC_W'(acc));
		chk("null_flag", 15'h0001, FRA_PC_W'(result_null_flag));
		peek(7'h05, 8'h01);
		issue(FRA_OP_DECREMENT_FILE_OP, 7'h05, 1'b1);
		issue(FRA_OP_DECREMENT_FILE_OP, 7'h05, 1'b1);
		chk("null_flag", 15'h0000, FRA_PC_W'(result_null_flag));
		chk("acc", 15'h0000, FRA_PC_W'(acc));
		peek(7'h05, 8'hFF);
		$display("test decrement done");
	endtask

	task automatic t_skip();
		issue(FRA_OP_ISKIP, 7'h05, 1'b0);
		chk("acc", 15'h0000, FRA_PC_W'(acc));
		chk("nop_slot", 15'h0001, FRA_PC_W'(nop_slot));
		chk("op_ready", 15'h0000, FRA_PC_W'(op_ready));
		// offered during the nop slot: must be dropped, not queued
		issue(FRA_OP_CLEAR_ACCUMULATOR_OP, 7'h00, 1'b0);
		chk("nop_slot", 15'h0000, FRA_PC_W'(nop_slot));
		chk("null_flag", 15'h0000, FRA_PC_W'(result_null_flag));
		peek(7'h05, 8'hFF);
		chk("null_flag", 15'h0000, FRA_PC_W'(result_null_flag));
		issue(FRA_OP_ISKIP, 7'h09, 1'b1);
		issue(FRA_OP_DSKIP, 7'h09, 1'b1);
		chk("nop_slot", 15'h0001, FRA_PC_W'(nop_slot));
		chk("null_flag", 15'h0000, FRA_PC_W'(result_null_flag));
		peek(7'h09, 8'h00);
		issue(FRA_OP_DSKIP, 7'h05, 1'b0);
		chk("acc", 15'h00FE, FRA_PC_W'(acc));
		chk("nop_slot", 15'h0000, FRA_PC_W'(nop_slot));
		chk("op_ready", 15'h0001, FRA_PC_W'(op_ready));
		$display("test skip done");
	endtask

	task automatic t_call();
		upper_pc_holding = 7'h5A;
		pc_start = pc;
		issue(FRA_OP_CALL_VIA_ACCUMULATOR, 7'h00, 1'b0);
		chk("push_valid", 15'h0001, FRA_PC_W'(push_valid));
		chk("stack_top", pc_start + 15'h0001, stack_top_data);
		chk("op_ready", 15'h0000, FRA_PC_W'(op_ready));
		op_valid = 1'b0;
		@(negedge ref_clk);
		chk("pc", 15'h5AFE, pc);
		chk("push_valid", 15'h0000, FRA_PC_W'(push_valid));
		chk("op_ready", 15'h0001, FRA_PC_W'(op_ready));
		chk("null_flag", 15'h0000, FRA_PC_W'(result_null_flag));
		$display("test call done");
	endtask

	// guards against a hang anywhere in the sequence
	initial begin
		repeat (2000) @(posedge ref_clk);
		bad_count++;
		$display("FAIL watchdog expected finish seen hang");
		wrap_up();
	end

	initial begin
		bad_count        = 0;
		samples_checked  = 0;
		rst_n            = 1'b0;
		op_valid         = 1'b0;
		op_code          = FRA_OP_NOP;
		op_faddr         = 7'h00;
		op_dest          = 1'b0;
		upper_pc_holding = 7'h00;
		peek_addr        = 7'h00;
		repeat (20) @(negedge ref_clk);
		rst_n = 1'b1;
		chk("pc", 15'h0000, pc);
		chk("null_flag", 15'h0000, FRA_PC_W'(result_null_flag));
		t_clear();
		t_dec();
		t_skip();
		t_call();
		wrap_up();
	end
endmodule // fra_core_tb
